// *** src/ptp_time_of_day_and_stamp_queue.sv ***
// time-of-day keeper, four pin load/capture units, two-step stamp queue
//
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ns
module ptp_time_of_day_and_stamp_queue (
	// clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_arst_n,
	// avalon-mm slave
	input  wire logic [7:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	// timing pins and unit events
	input  wire logic [3:0]  i_tpin,
	output logic      [3:0]  o_tpin,
	output logic      [3:0]  o_tpin_oe_n,
	output logic      [3:0]  o_ls_irq,
	// transmit stamps from egress
	input  wire logic        i_ts_valid,
	input  wire logic [2:0]  i_ts_rewriter_operation,
	input  wire logic        i_ts_to_cpu,
	input  wire logic [2:0]  i_ts_port,
	input  wire logic [5:0]  i_ts_id,
	input  wire logic [31:0] i_ts_time,
	// identifier allocation
	input  wire logic        i_id_req,
	output logic      [5:0]  o_id_grant,
	output logic             o_id_grant_valid,
	// time of day to the stamping units
	output logic      [47:0] o_tod_seconds,
	output logic      [29:0] o_tod_ns
);

	typedef struct packed {
		logic                   avs_wait;
		logic [31:0]            rdata;
		logic [47:0]            tod_seconds;
		logic [29:0]            tod_ns;
		logic [31:0]            rate_cfg;
		logic [29:0]            rate_cnt;
		logic [3:0][8:0]        ctrl;
		ptp_tod_pkg::ls_state_e [3:0] st;
		logic [3:0][47:0]       ls_sec;
		logic [3:0][29:0]       ls_ns;
		logic [3:0][31:0]       wf_hi;
		logic [3:0][31:0]       wf_lo;
		logic [3:0][31:0]       wf_cnt;
		logic [3:0]             pin_prev;
		logic [3:0]             pin_out;
		logic [3:0]             pin_oe_n;
		logic [3:0]             irq;
		logic [127:0][40:0]     q_mem;
		logic [6:0]             q_rd;
		logic [6:0]             q_wr;
		logic [7:0]             q_cnt;
		logic                   q_ovfl;
		logic [7:0]             port_dis;
		logic [63:0]            id_used;
		logic [5:0]             id_grant;
		logic                   id_gvld;
	} state_s;

	state_s s_reg;
	state_s s_next;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				old[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return old;
	endfunction : be_merge

	// adds a signed offset and renormalises into seconds
	function automatic logic [77:0] tod_add(input logic [47:0] sec,
		input logic [29:0] ns, input logic signed [32:0] d);
		logic signed [32:0] sum;
		logic signed [32:0] lim;
		logic [47:0]        s;
		lim = $signed({3'h0, ptp_tod_pkg::NS_PER_SEC});
		sum = $signed({3'h0, ns}) + d;
		s   = sec;
		if (sum >= lim) begin
			sum = sum - lim;
			s   = s + 48'h1;
		end else if (sum < 0) begin
			sum = sum + lim;
			s   = s - 48'h1;
		end
		return {s, sum[29:0]};
	endfunction : tod_add

	// lowest free hardware identifier, or the none value
	function automatic logic [5:0] find_free(input logic [63:0] used);
		logic [5:0] id;
		id = ptp_tod_pkg::ID_NONE;
		for (int i = 62; i >= ptp_tod_pkg::ID_FIRST_HW; i--) begin
			if (!used[i]) begin
				id = 6'(i);
			end
		end
		return id;
	endfunction : find_free

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic               acc;
		logic               wr_hit;
		logic [1:0]         ci;
		logic [4:0]         sub;
		logic [31:0]        w;
		logic [31:0]        rel;
		logic [3:0]         start;
		logic [1:0]         trim;
		logic signed [32:0] step;
		logic [77:0]        t;
		logic               sec_tick;
		logic               edge_seen;
		logic               fire;
		logic [31:0]        acc_ns;
		logic               push;
		logic               pop;
		logic [5:0]         nid;
		acc       = 1'b0;
		wr_hit    = 1'b0;
		ci        = i_avs_address[6:5];
		sub       = i_avs_address[4:0];
		w         = '0;
		rel       = '0;
		start     = '0;
		trim      = '0;
		step      = '0;
		t         = '0;
		sec_tick  = 1'b0;
		edge_seen = 1'b0;
		fire      = 1'b0;
		acc_ns    = '0;
		push      = 1'b0;
		pop       = 1'b0;
		nid       = '0;
		s_next    = s_reg;

		// one wait state: answer on the edge after the request is seen
		acc = (i_avs_read | i_avs_write) & s_reg.avs_wait;
		wr_hit = i_avs_write & ~s_reg.avs_wait;
		s_next.avs_wait = ~acc;

		// rate adjuster
		if (s_reg.rate_cfg[31:30] == ptp_tod_pkg::TRIM_PLUS ||
			s_reg.rate_cfg[31:30] == ptp_tod_pkg::TRIM_MINUS) begin
			if (s_reg.rate_cnt >= s_reg.rate_cfg[29:0]) begin
				s_next.rate_cnt = '0;
				trim = s_reg.rate_cfg[31:30];
			end else begin
				s_next.rate_cnt = s_reg.rate_cnt + 30'h1;
			end
		end else begin
			s_next.rate_cnt = '0;
		end
		step = $signed({1'b0, ptp_tod_pkg::NOM_STEP_NS});
		if (trim == ptp_tod_pkg::TRIM_PLUS) begin
			step = step + 33'sh1;
		end else if (trim == ptp_tod_pkg::TRIM_MINUS) begin
			step = step - 33'sh1;
		end
		t = tod_add(s_reg.tod_seconds, s_reg.tod_ns, step);
		sec_tick = (t[77:30] != s_reg.tod_seconds);

		// register writes
		if (wr_hit) begin
			if (!i_avs_address[7]) begin
				case (sub)
				ptp_tod_pkg::LS_CTRL: begin
					w = be_merge({23'h0, s_reg.ctrl[ci]}, i_avs_writedata,
						i_avs_byteenable);
					s_next.ctrl[ci] = w[8:0];
					start[ci] = w[ptp_tod_pkg::CTRL_GO];
					if (!w[ptp_tod_pkg::CTRL_GO]) begin
						s_next.st[ci] = ptp_tod_pkg::LS_IDLE;
					end
				end
				ptp_tod_pkg::LS_SEC_LO: begin
					s_next.ls_sec[ci][31:0] = be_merge(s_reg.ls_sec[ci][31:0],
						i_avs_writedata, i_avs_byteenable);
				end
				ptp_tod_pkg::LS_SEC_HI: begin
					w = be_merge({16'h0, s_reg.ls_sec[ci][47:32]},
						i_avs_writedata, i_avs_byteenable);
					s_next.ls_sec[ci][47:32] = w[15:0];
				end
				ptp_tod_pkg::LS_NSEC: begin
					w = be_merge({2'h0, s_reg.ls_ns[ci]}, i_avs_writedata,
						i_avs_byteenable);
					s_next.ls_ns[ci] = w[29:0];
				end
				ptp_tod_pkg::LS_WF_HIGH: begin
					s_next.wf_hi[ci] = be_merge(s_reg.wf_hi[ci],
						i_avs_writedata, i_avs_byteenable);
				end
				ptp_tod_pkg::LS_WF_LOW: begin
					s_next.wf_lo[ci] = be_merge(s_reg.wf_lo[ci],
						i_avs_writedata, i_avs_byteenable);
				end
				default: begin
				end
				endcase
			end else begin
				w = be_merge(32'h0, i_avs_writedata, i_avs_byteenable);
				case (i_avs_address)
				ptp_tod_pkg::RATE_OFS: begin
					s_next.rate_cfg = be_merge(s_reg.rate_cfg,
						i_avs_writedata, i_avs_byteenable);
				end
				ptp_tod_pkg::QSTAT_OFS: begin
					if (w[ptp_tod_pkg::ST_OVFL]) begin
						s_next.q_ovfl = 1'b0;
					end
				end
				ptp_tod_pkg::QADV_OFS: pop = (s_reg.q_cnt != 8'h0);
				ptp_tod_pkg::IDLO_OFS: rel[31:0] = w;
				ptp_tod_pkg::IDHI_OFS: rel[31:0] = w;
				ptp_tod_pkg::PDIS_OFS: s_next.port_dis = w[7:0];
				default: begin
				end
				endcase
			end
		end

		// load/capture units; later units win a same-cycle time load
		for (int k = 0; k < ptp_tod_pkg::N_CTRL; k++) begin
			s_next.irq[k] = 1'b0;
			s_next.pin_prev[k] = i_tpin[k];
			fire = 1'b0;
			edge_seen = s_reg.ctrl[k][ptp_tod_pkg::CTRL_INV] ?
				(s_reg.pin_prev[k] & ~i_tpin[k]) :
				(~s_reg.pin_prev[k] & i_tpin[k]);
			if (start[k]) begin
				if (s_next.ctrl[k][1:0] == ptp_tod_pkg::ACT_WAVE) begin
					s_next.wf_cnt[k] = '0;
					if (s_next.ctrl[k][ptp_tod_pkg::CTRL_SYNC]) begin
						s_next.st[k] = ptp_tod_pkg::LS_WAIT_S;
					end else begin
						s_next.st[k] = ptp_tod_pkg::LS_HIGH;
						s_next.pin_out[k] = ~s_next.ctrl[k][ptp_tod_pkg::CTRL_INV];
						s_next.irq[k] = s_next.ctrl[k][ptp_tod_pkg::CTRL_IRQ];
					end
				end else if (s_next.ctrl[k][ptp_tod_pkg::CTRL_SYNC] &&
					s_next.ctrl[k][1:0] != ptp_tod_pkg::ACT_DELTA) begin
					s_next.st[k] = ptp_tod_pkg::LS_ARMED;
				end else begin
					fire = 1'b1;
				end
			end else if (s_next.ctrl[k][ptp_tod_pkg::CTRL_GO]) begin
				// a go-cleared abort must not be undone by the running state
				case (s_reg.st[k])
				ptp_tod_pkg::LS_IDLE: begin
				end
				ptp_tod_pkg::LS_ARMED: fire = edge_seen;
				ptp_tod_pkg::LS_HIGH: begin
					acc_ns = s_reg.wf_cnt[k] + ptp_tod_pkg::NOM_STEP_NS;
					if (acc_ns >= s_reg.wf_hi[k]) begin
						s_next.wf_cnt[k] = acc_ns - s_reg.wf_hi[k];
						s_next.pin_out[k] = s_reg.ctrl[k][ptp_tod_pkg::CTRL_INV];
						if (s_reg.ctrl[k][ptp_tod_pkg::CTRL_SYNC]) begin
							s_next.st[k] = ptp_tod_pkg::LS_IDLE;
							s_next.ctrl[k][ptp_tod_pkg::CTRL_GO] = 1'b0;
						end else begin
							s_next.st[k] = ptp_tod_pkg::LS_LOW;
						end
					end else begin
						s_next.wf_cnt[k] = acc_ns;
					end
				end
				ptp_tod_pkg::LS_LOW: begin
					acc_ns = s_reg.wf_cnt[k] + ptp_tod_pkg::NOM_STEP_NS;
					if (acc_ns >= s_reg.wf_lo[k]) begin
						s_next.wf_cnt[k] = acc_ns - s_reg.wf_lo[k];
						s_next.st[k] = ptp_tod_pkg::LS_HIGH;
						s_next.pin_out[k] = ~s_reg.ctrl[k][ptp_tod_pkg::CTRL_INV];
						s_next.irq[k] = s_reg.ctrl[k][ptp_tod_pkg::CTRL_IRQ];
					end else begin
						s_next.wf_cnt[k] = acc_ns;
					end
				end
				ptp_tod_pkg::LS_WAIT_S: begin
					if (sec_tick) begin
						s_next.st[k] = ptp_tod_pkg::LS_DELAY;
					end
				end
				ptp_tod_pkg::LS_DELAY: begin
					if ({2'h0, s_reg.tod_ns} >= s_reg.wf_lo[k]) begin
						s_next.st[k] = ptp_tod_pkg::LS_HIGH;
						s_next.wf_cnt[k] = '0;
						s_next.pin_out[k] = ~s_reg.ctrl[k][ptp_tod_pkg::CTRL_INV];
						s_next.irq[k] = s_reg.ctrl[k][ptp_tod_pkg::CTRL_IRQ];
					end
				end
				default: s_next.st[k] = ptp_tod_pkg::LS_IDLE;
				endcase
			end
			if (fire) begin
				s_next.st[k] = ptp_tod_pkg::LS_IDLE;
				s_next.ctrl[k][ptp_tod_pkg::CTRL_GO] = 1'b0;
				s_next.irq[k] = s_next.ctrl[k][ptp_tod_pkg::CTRL_IRQ];
				case (s_next.ctrl[k][1:0])
				ptp_tod_pkg::ACT_LOAD: t = {s_next.ls_sec[k], s_next.ls_ns[k]};
				ptp_tod_pkg::ACT_DELTA: begin
					t = tod_add(t[77:30], t[29:0],
						s_next.ctrl[k][ptp_tod_pkg::CTRL_SUB] ?
						-$signed({3'h0, s_next.ls_ns[k]}) :
						$signed({3'h0, s_next.ls_ns[k]}));
				end
				ptp_tod_pkg::ACT_STORE: begin
					// capture wins over a same-cycle software write
					s_next.ls_sec[k] = s_reg.tod_seconds;
					s_next.ls_ns[k] = s_reg.tod_ns;
				end
				default: begin
				end
				endcase
			end
			// pin driven only while the waveform action is chosen
			s_next.pin_oe_n[k] = (s_next.ctrl[k][1:0] != ptp_tod_pkg::ACT_WAVE);
			if (s_next.st[k] == ptp_tod_pkg::LS_IDLE ||
				s_next.st[k] == ptp_tod_pkg::LS_WAIT_S ||
				s_next.st[k] == ptp_tod_pkg::LS_DELAY) begin
				s_next.pin_out[k] = s_next.ctrl[k][ptp_tod_pkg::CTRL_INV];
			end
		end
		s_next.tod_seconds = t[77:30];
		s_next.tod_ns = t[29:0];

		// stamp queue
		push = i_ts_valid && i_ts_rewriter_operation == ptp_tod_pkg::REW_TWO_STEP &&
			!i_ts_to_cpu &&
			!s_reg.port_dis[i_ts_port];
		if (pop) begin
			s_next.q_rd = s_reg.q_rd + 7'h1;
		end
		if (push) begin
			if (s_reg.q_cnt == ptp_tod_pkg::Q_FULL) begin
				s_next.q_ovfl = 1'b1;
				push = 1'b0;
			end else begin
				s_next.q_mem[s_reg.q_wr] = {i_ts_id, i_ts_port, i_ts_time};
				s_next.q_wr = s_reg.q_wr + 7'h1;
			end
		end
		s_next.q_cnt = s_reg.q_cnt + {7'h0, push} - {7'h0, pop};

		// identifiers: release, then allocate so a grant wins
		if (wr_hit && i_avs_address == ptp_tod_pkg::IDHI_OFS) begin
			s_next.id_used[63:32] = s_reg.id_used[63:32] & ~rel;
		end else if (wr_hit && i_avs_address == ptp_tod_pkg::IDLO_OFS) begin
			s_next.id_used[31:0] = s_reg.id_used[31:0] & ~rel;
		end
		s_next.id_gvld = i_id_req;
		if (i_id_req) begin
			nid = find_free(s_reg.id_used);
			s_next.id_grant = nid;
			if (nid != ptp_tod_pkg::ID_NONE) begin
				s_next.id_used[nid] = 1'b1;
			end
		end

		// read data, sampled in the request's first cycle
		if (acc && i_avs_read) begin
			s_next.rdata = '0;
			if (!i_avs_address[7]) begin
				case (sub)
				ptp_tod_pkg::LS_CTRL: s_next.rdata = {23'h0, s_reg.ctrl[ci]};
				ptp_tod_pkg::LS_SEC_LO: s_next.rdata = s_reg.ls_sec[ci][31:0];
				ptp_tod_pkg::LS_SEC_HI: s_next.rdata = {16'h0, s_reg.ls_sec[ci][47:32]};
				ptp_tod_pkg::LS_NSEC: s_next.rdata = {2'h0, s_reg.ls_ns[ci]};
				ptp_tod_pkg::LS_WF_HIGH: s_next.rdata = s_reg.wf_hi[ci];
				ptp_tod_pkg::LS_WF_LOW: s_next.rdata = s_reg.wf_lo[ci];
				default: s_next.rdata = '0;
				endcase
			end else begin
				case (i_avs_address)
				ptp_tod_pkg::TOD_NS_OFS: s_next.rdata = {2'h0, s_reg.tod_ns};
				ptp_tod_pkg::TOD_SLO_OFS: s_next.rdata = s_reg.tod_seconds[31:0];
				ptp_tod_pkg::TOD_SHI_OFS: s_next.rdata = {16'h0, s_reg.tod_seconds[47:32]};
				ptp_tod_pkg::RATE_OFS: s_next.rdata = s_reg.rate_cfg;
				ptp_tod_pkg::QSTAT_OFS: begin
					s_next.rdata[0] = (s_reg.q_cnt != 8'h0);
					s_next.rdata[ptp_tod_pkg::ST_ID_LSB +: 6] =
						s_reg.q_mem[s_reg.q_rd][40:35];
					s_next.rdata[ptp_tod_pkg::ST_PORT_LSB +: 3] =
						s_reg.q_mem[s_reg.q_rd][34:32];
					s_next.rdata[ptp_tod_pkg::ST_OVFL] = s_reg.q_ovfl;
				end
				ptp_tod_pkg::QTIME_OFS: s_next.rdata = s_reg.q_mem[s_reg.q_rd][31:0];
				ptp_tod_pkg::IDLO_OFS: s_next.rdata = s_reg.id_used[31:0];
				ptp_tod_pkg::IDHI_OFS: s_next.rdata = s_reg.id_used[63:32];
				ptp_tod_pkg::PDIS_OFS: s_next.rdata = {24'h0, s_reg.port_dis};
				default: s_next.rdata = '0;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s_reg          <= '0;
			s_reg.avs_wait <= ptp_tod_pkg::RST_WAIT;
			s_reg.pin_oe_n <= ptp_tod_pkg::RST_OE_N;
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_avs_readdata    = s_reg.rdata;
	assign o_avs_waitrequest = s_reg.avs_wait;
	assign o_tpin            = s_reg.pin_out;
	assign o_tpin_oe_n       = s_reg.pin_oe_n;
	assign o_ls_irq          = s_reg.irq;
	assign o_id_grant        = s_reg.id_grant;
	assign o_id_grant_valid  = s_reg.id_gvld;
	assign o_tod_seconds         = s_reg.tod_seconds;
	assign o_tod_ns          = s_reg.tod_ns;

endmodule : ptp_time_of_day_and_stamp_queue

// *** shared/ptp_tod_pkg.sv ***
// constants and types for the time-of-day and stamp queue block
package ptp_tod_pkg;
	localparam int unsigned CLK_RATE_HZ  = 20000000;
	localparam int unsigned NS_PER_S_INT = 1000000000;
	localparam logic [31:0] NOM_STEP_NS  = 32'(NS_PER_S_INT / CLK_RATE_HZ);
	localparam logic [29:0] NS_PER_SEC   = 30'h3B9ACA00;
	localparam int          N_CTRL       = 4;
	localparam int          Q_DEPTH      = 128;
	localparam logic [7:0]  Q_FULL       = 8'h80;
	localparam logic [2:0]  REW_TWO_STEP = 3'h3;
	localparam logic [5:0]  ID_NONE      = 6'h3F;
	localparam int          ID_FIRST_HW  = 4;
	// per-controller register offsets, controller n at n times 0x20
	localparam logic [4:0]  LS_CTRL      = 5'h00;
	localparam logic [4:0]  LS_SEC_LO    = 5'h04;
	localparam logic [4:0]  LS_SEC_HI    = 5'h08;
	localparam logic [4:0]  LS_NSEC      = 5'h0C;
	localparam logic [4:0]  LS_WF_HIGH   = 5'h10;
	localparam logic [4:0]  LS_WF_LOW    = 5'h14;
	// shared register byte offsets
	localparam logic [7:0]  TOD_NS_OFS   = 8'h80;
	localparam logic [7:0]  TOD_SLO_OFS  = 8'h84;
	localparam logic [7:0]  TOD_SHI_OFS  = 8'h88;
	localparam logic [7:0]  RATE_OFS     = 8'h8C;
	localparam logic [7:0]  QSTAT_OFS    = 8'h90;
	localparam logic [7:0]  QTIME_OFS    = 8'h94;
	localparam logic [7:0]  QADV_OFS     = 8'h98;
	localparam logic [7:0]  IDLO_OFS     = 8'h9C;
	localparam logic [7:0]  IDHI_OFS     = 8'hA0;
	localparam logic [7:0]  PDIS_OFS     = 8'hA4;
	// field positions
	localparam int          CTRL_SYNC    = 2;
	localparam int          CTRL_INV     = 3;
	localparam int          CTRL_IRQ     = 4;
	localparam int          CTRL_SUB     = 5;
	localparam int          CTRL_GO      = 8;
	localparam int          RATE_MODE    = 30;
	localparam int          ST_ID_LSB    = 1;
	localparam int          ST_PORT_LSB  = 7;
	localparam int          ST_OVFL      = 16;
	// reset values
	localparam logic [3:0]  RST_OE_N     = 4'hF;
	localparam logic        RST_WAIT     = 1'b1;
	typedef enum logic [1:0] {
		ACT_LOAD  = 2'b00,
		ACT_DELTA = 2'b01,
		ACT_STORE = 2'b10,
		ACT_WAVE  = 2'b11
	} ls_action_e;
	typedef enum logic [2:0] {
		LS_IDLE   = 3'b000,
		LS_ARMED  = 3'b001,
		LS_HIGH   = 3'b010,
		LS_LOW    = 3'b011,
		LS_WAIT_S = 3'b100,
		LS_DELAY  = 3'b101
	} ls_state_e;
	localparam logic [1:0]  TRIM_PLUS    = 2'b01;
	localparam logic [1:0]  TRIM_MINUS   = 2'b10;
endpackage : ptp_tod_pkg

// *** test/ptp_tod_properties.sv ***
// port-level checks for the time-of-day and stamp queue block
`timescale 1ns/1ns
module ptp_tod_checker (
	input  wire logic        i_clock,
	input  wire logic        i_arst_n,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] o_avs_readdata,
	input  wire logic        o_avs_waitrequest,
	input  wire logic        i_id_req,
	input  wire logic [5:0]  o_id_grant,
	input  wire logic        o_id_grant_valid,
	input  wire logic [47:0] o_tod_seconds,
	input  wire logic [29:0] o_tod_ns
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);
	////////////////////////////////////////////////////////////////////////////
	// writes may load or offset time, so those cycles are left out
	AST_TOD_STEP: assert property (!$past(i_avs_write) &&
		$past(i_arst_n) &&
		$past(o_tod_ns) < 30'd999999949 |-> $stable(o_tod_seconds) &&
		(o_tod_ns - $past(o_tod_ns)) inside {30'd49, 30'd50, 30'd51})
		else $error("time step out of range");
	AST_NS_WRAP: assert property (!$past(i_avs_write) &&
		$past(o_tod_ns) > 30'd999999951 |-> o_tod_ns < 30'd52 &&
		o_tod_seconds == $past(o_tod_seconds) + 48'h1)
		else $error("nanoseconds did not wrap into seconds");
	AST_NS_RANGE: assert property (o_tod_ns < ptp_tod_pkg::NS_PER_SEC)
		else $error("nanoseconds beyond one second");
	AST_WAIT_ONE: assert property ($rose(i_avs_read || i_avs_write)
		|=> !o_avs_waitrequest)
		else $error("bus answer not after one wait cycle");
	AST_WAIT_BACK: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	AST_RDATA_HOLD: assert property (!$stable(o_avs_readdata)
		|-> !o_avs_waitrequest)
		else $error("read data changed outside an answer");
	AST_GRANT: assert property (i_id_req |=> o_id_grant_valid &&
		o_id_grant > 6'h03)
		else $error("identifier grant missing or reserved");
	AST_GRANT_CAUSE: assert property (o_id_grant_valid |-> $past(i_id_req))
		else $error("identifier grant without request");
endmodule : ptp_tod_checker
////////////////////////////////////////////////////////////////////////////////
bind ptp_time_of_day_and_stamp_queue ptp_tod_checker u_chk (.i_clock,
	.i_arst_n, .i_avs_read, .i_avs_write, .o_avs_readdata, .o_avs_waitrequest,
	.i_id_req, .o_id_grant, .o_id_grant_valid, .o_tod_seconds, .o_tod_ns);

// *** test/ptp_pin_source.sv ***
// external timing equipment driving the four timing pins
`timescale 1ns/1ns
module ptp_pin_source (
	// clock and reset
	input  wire logic       i_clock,
	input  wire logic       i_arst_n,
	// requested levels, fast pins lag one cycle, slow pins two
	input  wire logic [3:0] i_level,
	input  wire logic [3:0] i_slow,
	output logic      [3:0] o_tpin
);
	logic [3:0] stage_reg;
	// alternate pin function taken as enabled before any unit is used
	// receive delay trims are software work after link-up, not here
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			stage_reg <= 4'h0;
			o_tpin    <= 4'h0;
		end else begin
			stage_reg <= i_level;
			o_tpin    <= (i_slow & stage_reg) | (~i_slow & i_level);
		end
	end
endmodule : ptp_pin_source

// *** test/ptp_time_of_day_and_stamp_queue_test.sv ***
// self-checking bench for the time-of-day and stamp queue block
`timescale 1ns/1ns
module ptp_time_of_day_and_stamp_queue_test;
	logic        i_clock;
	logic        i_arst_n;
	logic [7:0]  adr;
	logic        rd;
	logic        wr;
	logic [31:0] wd;
	logic [31:0] rdata;
	logic        wait_req;
	logic [3:0]  lvl;
	logic [3:0]  pin;
	logic [3:0]  tpo;
	logic [3:0]  oe_n;
	logic [3:0]  irq;
	logic        ts_v;
	logic [2:0]  ts_op;
	logic        ts_cpu;
	logic [2:0]  ts_port;
	logic [5:0]  ts_id;
	logic [31:0] ts_time;
	logic        id_req;
	logic [5:0]  grant;
	logic        grant_v;
	logic [47:0] sec;
	logic [29:0] ns;
	logic [31:0] q;
	int          mismatches;
	int          n_tests;
	int          cyc;
	ptp_time_of_day_and_stamp_queue u_dut (.i_clock(i_clock),
		.i_arst_n(i_arst_n), .i_avs_address(adr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .i_tpin(pin),
		.o_tpin(tpo), .o_tpin_oe_n(oe_n), .o_ls_irq(irq), .i_ts_valid(ts_v),
		.i_ts_rewriter_operation(ts_op), .i_ts_to_cpu(ts_cpu), .i_ts_port(ts_port),
		.i_ts_id(ts_id), .i_ts_time(ts_time), .i_id_req(id_req),
		.o_id_grant(grant), .o_id_grant_valid(grant_v), .o_tod_seconds(sec),
		.o_tod_ns(ns));
	ptp_pin_source u_pins (.i_clock(i_clock), .i_arst_n(i_arst_n),
		.i_level(lvl), .i_slow(4'h4), .o_tpin(pin));
	initial begin
		i_clock = 1'b0;
		forever #25 i_clock = ~i_clock;
	end
	// generous ceiling, the queue fill and drain dominate the run
	always @(posedge i_clock) begin
		cyc = cyc + 1;
		if (cyc > 20000) begin
			mismatches++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : final_report
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	function automatic logic [7:0] ra(input logic [2:0] u, input logic [4:0] o);
		return {u, o};
	endfunction : ra
	// entered at a rising edge; one idle edge after release keeps strobes clean
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge i_clock);
		end while (wait_req !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge i_clock);
	endtask : bus
	task automatic wirq(input int u);
		int n;
		n = 0;
		while (irq[u] !== 1'b1 && n < 10) begin
			@(posedge i_clock);
			n++;
		end
		check(irq, 4'h1 << u);
	endtask : wirq
	task automatic offer(input logic [2:0] op, input logic c, input int i);
		ts_v <= 1'b1;
		ts_op <= op;
		ts_cpu <= c;
		ts_port <= 3'(i + 3);
		ts_id <= 6'(i + 9);
		ts_time <= 32'hA000 + 32'(i);
		@(posedge i_clock);
		ts_v <= 1'b0;
		@(posedge i_clock);
	endtask : offer
	////////////////////////////////////////////////////////////////////////////
	task automatic t_rate;
		logic [29:0] a;
		a = ns;
		@(posedge i_clock);
		check(ns - a, ptp_tod_pkg::NOM_STEP_NS);
		for (int m = 1; m < 3; m++) begin
			bus(1'b1, ptp_tod_pkg::RATE_OFS, (m << 30) | 32'h3);
			a = ns;
			repeat (8) @(posedge i_clock);
			check(ns - a, 8 * ptp_tod_pkg::NOM_STEP_NS + 6 - 4 * m);
		end
		bus(1'b1, ptp_tod_pkg::RATE_OFS, 32'h0);
		$display("rate test done");
	endtask : t_rate
	task automatic t_load;
		bus(1'b1, ra(0, ptp_tod_pkg::LS_SEC_LO), 32'h89ABCDEF);
		bus(1'b1, ra(0, ptp_tod_pkg::LS_SEC_HI), 32'h00001234);
		bus(1'b1, ra(0, ptp_tod_pkg::LS_NSEC), 32'd999999920);
		bus(1'b1, ra(0, ptp_tod_pkg::LS_CTRL), 32'h110);
		check(ns, 30'd999999920);
		check(sec, 48'h123489ABCDEF);
		wirq(0);
		repeat (3) @(posedge i_clock);
		check(sec, 48'h123489ABCDF0);
		$display("load test done");
	endtask : t_load
	task automatic t_store;
		logic [29:0] a;
		bus(1'b1, ra(1, ptp_tod_pkg::LS_CTRL), 32'h102);
		bus(1'b0, ra(1, ptp_tod_pkg::LS_SEC_LO), 32'h0);
		check(q, 32'h89ABCDF0);
		bus(1'b1, ra(3, ptp_tod_pkg::LS_NSEC), 32'd1000);
		a = ns;
		bus(1'b1, ra(3, ptp_tod_pkg::LS_CTRL), 32'h101);
		check(ns - a inside {30'd1100, 30'd1150}, 1'b1);
		bus(1'b0, 8'hFC, 32'h0);
		check(q, 32'h0);
		a = ns;
		bus(1'b1, ra(3, ptp_tod_pkg::LS_CTRL), 32'h121);
		check(a - ns, 30'd850);
		$display("store test done");
	endtask : t_store
	task automatic t_sync;
		bus(1'b1, ra(2, ptp_tod_pkg::LS_CTRL), 32'h11E);
		lvl <= 4'h4;
		repeat (6) @(posedge i_clock);
		bus(1'b0, ra(2, ptp_tod_pkg::LS_CTRL), 32'h0);
		check(q[ptp_tod_pkg::CTRL_GO], 1'b1);
		lvl <= 4'h0;
		wirq(2);
		bus(1'b0, ra(2, ptp_tod_pkg::LS_SEC_LO), 32'h0);
		check(q, 32'h89ABCDF0);
		$display("sync test done");
	endtask : t_sync
	task automatic t_wave;
		int n;
		int h;
		int l;
		int k;
		bus(1'b1, ra(1, ptp_tod_pkg::LS_WF_HIGH), 32'd100);
		bus(1'b1, ra(1, ptp_tod_pkg::LS_WF_LOW), 32'd150);
		for (int v = 0; v < 2; v++) begin
			bus(1'b1, ra(1, ptp_tod_pkg::LS_CTRL), 32'h113 | (v << 3));
			check(oe_n[1], 1'b0);
			n = 0;
			h = 0;
			l = 0;
			k = 0;
			while (tpo[1] === v[0] && n < 20) begin @(posedge i_clock); n++; end
			while (tpo[1] !== v[0] && h < 20) begin @(posedge i_clock); h++; end
			while (tpo[1] === v[0] && l < 20) begin @(posedge i_clock); l++; end
			repeat (10) begin k = k + irq[1]; @(posedge i_clock); end
			check(h, 100 / ptp_tod_pkg::NOM_STEP_NS);
			check(l, 150 / ptp_tod_pkg::NOM_STEP_NS);
			check(k, 2);
			bus(1'b1, ra(1, ptp_tod_pkg::LS_CTRL), v << 3);
			@(posedge i_clock);
			check({oe_n[1], tpo[1]}, {1'b1, v[0]});
		end
		bus(1'b1, ra(0, ptp_tod_pkg::LS_NSEC), 32'd999999500);
		bus(1'b1, ra(0, ptp_tod_pkg::LS_CTRL), 32'h100);
		bus(1'b1, ra(1, ptp_tod_pkg::LS_CTRL), 32'h117);
		n = 0;
		h = 0;
		while (tpo[1] !== 1'b1 && n < 40) begin @(posedge i_clock); n++; end
		check(ns >= 30'd150 && ns < 30'd1000, 1'b1);
		while (tpo[1] === 1'b1 && h < 20) begin @(posedge i_clock); h++; end
		check(h, 2);
		$display("wave test done");
	endtask : t_wave
	task automatic t_queue;
		bus(1'b1, ptp_tod_pkg::PDIS_OFS, 32'h10);
		offer(3'h2, 1'b0, 0);
		offer(ptp_tod_pkg::REW_TWO_STEP, 1'b1, 0);
		offer(ptp_tod_pkg::REW_TWO_STEP, 1'b0, 1);
		bus(1'b0, ptp_tod_pkg::QSTAT_OFS, 32'h0);
		check(q[0], 1'b0);
		bus(1'b1, ptp_tod_pkg::PDIS_OFS, 32'h0);
		for (int i = 0; i <= ptp_tod_pkg::Q_DEPTH; i++) offer(3'h3, 1'b0, i);
		bus(1'b0, ptp_tod_pkg::QSTAT_OFS, 32'h0);
		check(q, 32'h10193);
		bus(1'b0, ptp_tod_pkg::QTIME_OFS, 32'h0);
		check(q, 32'hA000);
		for (int i = 1; i < ptp_tod_pkg::Q_DEPTH; i++)
			bus(1'b1, ptp_tod_pkg::QADV_OFS, 32'h0);
		bus(1'b0, ptp_tod_pkg::QSTAT_OFS, 32'h0);
		check(q[6:0], {6'(127 + 9), 1'b1});
		bus(1'b1, ptp_tod_pkg::QADV_OFS, 32'h0);
		bus(1'b1, ptp_tod_pkg::QSTAT_OFS, 32'h10000);
		bus(1'b0, ptp_tod_pkg::QSTAT_OFS, 32'h0);
		check({q[16], q[0]}, 2'b00);
		$display("queue test done");
	endtask : t_queue
	task automatic t_ids;
		for (int i = ptp_tod_pkg::ID_FIRST_HW; i < 65; i++) begin
			if (i == 64) bus(1'b1, ptp_tod_pkg::IDLO_OFS, 32'h20);
			id_req <= 1'b1;
			@(posedge i_clock);
			id_req <= 1'b0;
			@(posedge i_clock);
			if (i == 63) check(grant, ptp_tod_pkg::ID_NONE);
			else if (i == 64) check(grant, 6'h05);
			else check(grant > 6'h03 && grant < 6'h3F, 1'b1);
		end
		bus(1'b0, ptp_tod_pkg::IDHI_OFS, 32'h0);
		check(q, 32'h7FFFFFFF);
		bus(1'b1, ptp_tod_pkg::IDHI_OFS, 32'hFFFFFFFF);
		bus(1'b0, ptp_tod_pkg::IDHI_OFS, 32'h0);
		check(q, 32'h0);
		$display("id test done");
	endtask : t_ids
	////////////////////////////////////////////////////////////////////////////
	initial begin
		{i_arst_n, adr, rd, wr, wd, lvl, ts_v, ts_op, ts_cpu} = '0;
		{ts_port, ts_id, ts_time, id_req} = '0;
		mismatches = 0;
		n_tests = 0;
		cyc = 0;
		repeat (6) @(posedge i_clock);
		check({wait_req, oe_n, sec}, {1'b1, ptp_tod_pkg::RST_OE_N, 48'h0});
		i_arst_n <= 1'b1;
		@(posedge i_clock);
		t_rate();
		t_load();
		t_store();
		t_sync();
		t_wave();
		t_queue();
		t_ids();
		final_report();
	end
endmodule : ptp_time_of_day_and_stamp_queue_test
